// ---- verilog/mitd_pkg.sv ----
package mitd_pkg;
    // operand and word widths of the core
    localparam int DATA_W = 8;
    localparam int BIT_W = 3;
    localparam int PC_W = 13;
    localparam int STACK_DEPTH = 16;
    localparam int TBL_W = 16;
    // data memory location that aliases the low byte of the program counter
    localparam logic [7:0] PCL_ADDR = 8'h02;
    // four system clocks make one instruction cycle
    localparam int CLKS_PER_CYCLE = 4;
    localparam logic [1:0] PH_FETCH = 2'h3;
    localparam logic [1:0] PH_EXEC = 2'h2;
    localparam logic [1:0] PH_FIRST = 2'h0;
    // instruction cycles beyond the first
    localparam logic [1:0] XTRA_NONE = 2'h0;
    localparam logic [1:0] XTRA_ONE = 2'h1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hff;
    localparam logic [7:0] BYTE_ONE = 8'h01;

    typedef enum logic [5:0] {
        OP_NOP, OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_TO_ACC, OP_ROTATE_RIGHT_CARRY,
        OP_ROTATE_RIGHT_CARRY_TO_ACC, OP_ROTATE_LEFT, OP_ROTATE_LEFT_TO_ACC,
        OP_ROTATE_LEFT_CARRY, OP_ROTATE_LEFT_CARRY_TO_ACC, OP_MOVE_MEM_TO_ACC,
        OP_MOVE_ACC_TO_MEM, OP_MOVE_IMM_TO_ACC, OP_BIT_CLEAR, OP_BIT_SET,
        OP_JUMP_ABSOLUTE, OP_SKIP_IF_ZERO, OP_SKIP_ZERO_MOVE_ACC, OP_SKIP_BIT_ZERO,
        OP_SKIP_BIT_NONZERO, OP_INCREMENT_SKIP_ZERO, OP_DECREMENT_SKIP_ZERO,
        OP_INCREMENT_SKIP_ZERO_ACC, OP_DECREMENT_SKIP_ZERO_ACC, OP_CALL,
        OP_RETURN, OP_RETURN_LOAD_ACC, OP_RETURN_FROM_INTERRUPT,
        OP_TABLE_READ_CURRENT_PAGE, OP_TABLE_READ_LAST_PAGE, OP_BYTE_CLEAR,
        OP_BYTE_SET, OP_WATCHDOG_CLEAR, OP_WATCHDOG_PRECLEAR_FIRST,
        OP_WATCHDOG_PRECLEAR_SECOND, OP_NIBBLE_EXCHANGE, OP_NIBBLE_EXCHANGE_TO_ACC,
        OP_HALT
    } mitd_op_t;

    typedef enum {MITD_RUN, MITD_SLEEP} mitd_fsm_t;
endpackage

// ---- verilog/mitd_core.sv ----
// Operation
// RULE1 - right rotates: plain keep flags, carry forms update carry, acc forms spare memory
// RULE2 - left rotates: plain keep flags, carry forms update carry, acc forms spare memory
// RULE3 - moves take one cycle, no flags; memory form gains a cycle on pc low
// RULE4 - bit clear/set forces selected bit 0..7 of a byte, flags untouched
// RULE5 - jump loads program counter, two cycles, no flags
// RULE6 - test-and-skip on zero byte or selected bit state; move form copies to acc
// RULE7 - increment/decrement-skip on zero result; memory form may pay both penalties
// RULE8 - call, return, return-with-immediate and interrupt return take two cycles
// RULE9 - table read from current or last page, low to memory, high to table byte
// RULE10 - no-op one cycle; byte clear/set write all zeros or all ones
// RULE11 - single watchdog clear resets watchdog, clears timeout and powerdown flags
// RULE12 - pre-clear pair clears watchdog and flags only when both were executed
// RULE13 - nibble swap exchanges halves, result to memory or accumulator
// RULE14 - halt enters power-down in one cycle, updating timeout and powerdown flags
// RULE15 - a write to program counter low adds one cycle of four clocks
// RULE16 - a taken skip adds one cycle; otherwise base count unchanged
// RULE17 - accumulator and operands are eight bits, bit index three bits
`timescale 1ns/1ps
module mitd_core #(
    parameter int PC_W = mitd_pkg::PC_W,
    parameter int STACK_DEPTH = mitd_pkg::STACK_DEPTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire mitd_pkg::mitd_op_t instr_op,
    input wire logic [mitd_pkg::BIT_W-1:0] instr_bit,
    input wire logic [PC_W-1:0] instr_operand,
    input wire logic [mitd_pkg::DATA_W-1:0] mem_rdata,
    input wire logic [mitd_pkg::TBL_W-1:0] tbl_data,
    input wire logic wdt_timeout,
    input wire logic wake,
    output logic [PC_W-1:0] pc,
    output logic fetch,
    output logic [mitd_pkg::DATA_W-1:0] mem_addr,
    output logic [mitd_pkg::DATA_W-1:0] mem_wdata,
    output logic mem_we,
    output logic [PC_W-1:0] tbl_addr,
    output logic [mitd_pkg::DATA_W-1:0] table_high_byte,
    output logic [mitd_pkg::DATA_W-1:0] acc,
    output logic carry,
    output logic timeout_flag,
    output logic powerdown_flag,
    output logic wdt_clear,
    output logic halted,
    output logic int_enable
);
    localparam int SP_W = $clog2(STACK_DEPTH);
    localparam int DW = mitd_pkg::DATA_W;

    typedef struct packed {
        mitd_pkg::mitd_fsm_t fsm;
        logic [1:0] phase;
        logic [1:0] cyc_left;
        logic first;
        logic skip_taken;
        logic go_sleep;
        logic sleeping;
        mitd_pkg::mitd_op_t op;
        logic [mitd_pkg::BIT_W-1:0] bitsel;
        logic [PC_W-1:0] operand;
        logic [PC_W-1:0] pc;
        logic fetch;
        logic [DW-1:0] mem_addr;
        logic [DW-1:0] mem_wdata;
        logic mem_we;
        logic [PC_W-1:0] tbl_addr;
        logic [DW-1:0] tbl_high;
        logic [DW-1:0] acc;
        logic carry;
        logic timeout;
        logic powerdown;
        logic wdt_clear;
        logic pend_first;
        logic pend_second;
        logic int_en;
        logic [SP_W-1:0] sp;
        logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
    } mitd_state_t;

    mitd_state_t s_q;
    mitd_state_t s_d;

    // datapath and sequencer; execution happens in phase 2 of an instruction's first cycle
    always_comb begin
        logic [DW-1:0] d;
        logic [DW-1:0] res;
        logic wr_mem;
        logic wr_acc;
        logic skip;
        logic [1:0] extra;
        logic [PC_W-1:0] pc_next;
        d = mem_rdata;
        res = d;
        wr_mem = 1'b0;
        wr_acc = 1'b0;
        skip = 1'b0;
        extra = mitd_pkg::XTRA_NONE;
        pc_next = s_q.pc + PC_W'(1);
        s_d = s_q;
        s_d.fetch = 1'b0;
        s_d.mem_we = 1'b0;
        s_d.wdt_clear = 1'b0;
        unique case (s_q.fsm)
            mitd_pkg::MITD_RUN: begin
                s_d.phase = s_q.phase + 2'(1);
                if (s_q.phase == mitd_pkg::PH_EXEC && s_q.first) begin
                    unique case (s_q.op)
                        mitd_pkg::OP_NOP: ; // RULE10
                        mitd_pkg::OP_ROTATE_RIGHT, mitd_pkg::OP_ROTATE_RIGHT_TO_ACC: begin
                            res = {d[0], d[DW-1:1]}; // RULE1
                            wr_mem = (s_q.op == mitd_pkg::OP_ROTATE_RIGHT);
                            wr_acc = !wr_mem;
                        end
                        mitd_pkg::OP_ROTATE_RIGHT_CARRY, mitd_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
                            res = {s_q.carry, d[DW-1:1]}; // RULE1
                            s_d.carry = d[0];
                            wr_mem = (s_q.op == mitd_pkg::OP_ROTATE_RIGHT_CARRY);
                            wr_acc = !wr_mem;
                        end
                        mitd_pkg::OP_ROTATE_LEFT, mitd_pkg::OP_ROTATE_LEFT_TO_ACC: begin
                            res = {d[DW-2:0], d[DW-1]}; // RULE2
                            wr_mem = (s_q.op == mitd_pkg::OP_ROTATE_LEFT);
                            wr_acc = !wr_mem;
                        end
                        mitd_pkg::OP_ROTATE_LEFT_CARRY, mitd_pkg::OP_ROTATE_LEFT_CARRY_TO_ACC: begin
                            res = {d[DW-2:0], s_q.carry}; // RULE2
                            s_d.carry = d[DW-1];
                            wr_mem = (s_q.op == mitd_pkg::OP_ROTATE_LEFT_CARRY);
                            wr_acc = !wr_mem;
                        end
                        mitd_pkg::OP_MOVE_MEM_TO_ACC: wr_acc = 1'b1; // RULE3
                        mitd_pkg::OP_MOVE_IMM_TO_ACC: begin
                            res = s_q.operand[DW-1:0]; // RULE3
                            wr_acc = 1'b1;
                        end
                        mitd_pkg::OP_MOVE_ACC_TO_MEM: begin
                            res = s_q.acc; // RULE3
                            wr_mem = 1'b1;
                        end
                        mitd_pkg::OP_BIT_CLEAR, mitd_pkg::OP_BIT_SET: begin
                            res[s_q.bitsel] = (s_q.op == mitd_pkg::OP_BIT_SET); // RULE4 RULE17
                            wr_mem = 1'b1;
                        end
                        mitd_pkg::OP_JUMP_ABSOLUTE: begin
                            pc_next = s_q.operand; // RULE5
                            extra = mitd_pkg::XTRA_ONE;
                        end
                        mitd_pkg::OP_SKIP_IF_ZERO: skip = (d == mitd_pkg::BYTE_ZERO); // RULE6
                        mitd_pkg::OP_SKIP_ZERO_MOVE_ACC: begin
                            skip = (d == mitd_pkg::BYTE_ZERO); // RULE6
                            wr_acc = 1'b1;
                        end
                        mitd_pkg::OP_SKIP_BIT_ZERO: skip = !d[s_q.bitsel]; // RULE6
                        mitd_pkg::OP_SKIP_BIT_NONZERO: skip = d[s_q.bitsel]; // RULE6
                        mitd_pkg::OP_INCREMENT_SKIP_ZERO, mitd_pkg::OP_INCREMENT_SKIP_ZERO_ACC,
                        mitd_pkg::OP_DECREMENT_SKIP_ZERO, mitd_pkg::OP_DECREMENT_SKIP_ZERO_ACC: begin
                            if (s_q.op == mitd_pkg::OP_INCREMENT_SKIP_ZERO
                                || s_q.op == mitd_pkg::OP_INCREMENT_SKIP_ZERO_ACC) begin
                                res = d + mitd_pkg::BYTE_ONE; // RULE7
                            end else begin
                                res = d - mitd_pkg::BYTE_ONE;
                            end
                            skip = (res == mitd_pkg::BYTE_ZERO);
                            wr_mem = (s_q.op == mitd_pkg::OP_INCREMENT_SKIP_ZERO
                                || s_q.op == mitd_pkg::OP_DECREMENT_SKIP_ZERO);
                            wr_acc = !wr_mem;
                        end
                        mitd_pkg::OP_CALL: begin
                            s_d.stack[s_q.sp] = s_q.pc + PC_W'(1); // RULE8
                            s_d.sp = s_q.sp + SP_W'(1);
                            pc_next = s_q.operand;
                            extra = mitd_pkg::XTRA_ONE;
                        end
                        mitd_pkg::OP_RETURN, mitd_pkg::OP_RETURN_LOAD_ACC,
                        mitd_pkg::OP_RETURN_FROM_INTERRUPT: begin
                            s_d.sp = s_q.sp - SP_W'(1); // RULE8
                            pc_next = s_q.stack[s_d.sp];
                            extra = mitd_pkg::XTRA_ONE;
                            res = s_q.operand[DW-1:0];
                            wr_acc = (s_q.op == mitd_pkg::OP_RETURN_LOAD_ACC);
                            if (s_q.op == mitd_pkg::OP_RETURN_FROM_INTERRUPT) begin
                                s_d.int_en = 1'b1;
                            end
                        end
                        mitd_pkg::OP_TABLE_READ_CURRENT_PAGE, mitd_pkg::OP_TABLE_READ_LAST_PAGE: begin
                            res = tbl_data[DW-1:0]; // RULE9
                            s_d.tbl_high = tbl_data[mitd_pkg::TBL_W-1:DW];
                            wr_mem = 1'b1;
                            extra = mitd_pkg::XTRA_ONE;
                        end
                        mitd_pkg::OP_BYTE_CLEAR, mitd_pkg::OP_BYTE_SET: begin
                            res = (s_q.op == mitd_pkg::OP_BYTE_SET) ? mitd_pkg::BYTE_ONES
                                : mitd_pkg::BYTE_ZERO; // RULE10
                            wr_mem = 1'b1;
                        end
                        mitd_pkg::OP_WATCHDOG_CLEAR: begin
                            s_d.wdt_clear = 1'b1; // RULE11
                            s_d.timeout = 1'b0;
                            s_d.powerdown = 1'b0;
                        end
                        mitd_pkg::OP_WATCHDOG_PRECLEAR_FIRST, mitd_pkg::OP_WATCHDOG_PRECLEAR_SECOND: begin
                            // the partner's pending mark decides; a repeat of the same half only re-marks
                            if ((s_q.op == mitd_pkg::OP_WATCHDOG_PRECLEAR_FIRST) ? s_q.pend_second
                                : s_q.pend_first) begin
                                s_d.wdt_clear = 1'b1; // RULE12
                                s_d.timeout = 1'b0;
                                s_d.powerdown = 1'b0;
                                s_d.pend_first = 1'b0;
                                s_d.pend_second = 1'b0;
                            end else if (s_q.op == mitd_pkg::OP_WATCHDOG_PRECLEAR_FIRST) begin
                                s_d.pend_first = 1'b1;
                            end else begin
                                s_d.pend_second = 1'b1;
                            end
                        end
                        mitd_pkg::OP_NIBBLE_EXCHANGE, mitd_pkg::OP_NIBBLE_EXCHANGE_TO_ACC: begin
                            res = {d[DW/2-1:0], d[DW-1:DW/2]}; // RULE13
                            wr_mem = (s_q.op == mitd_pkg::OP_NIBBLE_EXCHANGE);
                            wr_acc = !wr_mem;
                        end
                        mitd_pkg::OP_HALT: begin
                            s_d.go_sleep = 1'b1; // RULE14
                            s_d.wdt_clear = 1'b1;
                            s_d.timeout = 1'b0;
                            s_d.powerdown = 1'b1;
                        end
                        default: ;
                    endcase
                    if (skip) begin
                        pc_next = s_q.pc + PC_W'(2); // RULE16
                        extra = extra + mitd_pkg::XTRA_ONE;
                    end
                    // a low-byte load keeps the page of the current instruction
                    if (wr_mem && s_q.mem_addr == mitd_pkg::PCL_ADDR) begin
                        pc_next = {s_q.pc[PC_W-1:DW], res}; // RULE15
                        extra = extra + mitd_pkg::XTRA_ONE;
                    end
                    if (wr_acc) begin
                        s_d.acc = res;
                    end
                    s_d.mem_wdata = res;
                    s_d.mem_we = wr_mem;
                    s_d.skip_taken = skip;
                    s_d.cyc_left = extra;
                    s_d.pc = pc_next;
                end
                if (s_q.phase == mitd_pkg::PH_FETCH) begin
                    s_d.first = 1'b0;
                    if (s_q.cyc_left != mitd_pkg::XTRA_NONE) begin
                        s_d.cyc_left = s_q.cyc_left - 2'(1); // RULE15 RULE16
                    end else if (s_q.go_sleep) begin
                        s_d.fsm = mitd_pkg::MITD_SLEEP; // RULE14
                        s_d.go_sleep = 1'b0;
                        s_d.sleeping = 1'b1;
                        s_d.phase = mitd_pkg::PH_FETCH;
                    end else begin
                        // latch the word that program memory shows for the updated counter
                        s_d.fetch = 1'b1;
                        s_d.first = 1'b1;
                        s_d.skip_taken = 1'b0;
                        s_d.op = instr_op;
                        s_d.bitsel = instr_bit;
                        s_d.operand = instr_operand;
                        s_d.mem_addr = instr_operand[DW-1:0];
                        s_d.tbl_addr = (instr_op == mitd_pkg::OP_TABLE_READ_LAST_PAGE)
                            ? {{(PC_W-DW){1'b1}}, s_q.acc}
                            : {s_q.pc[PC_W-1:DW], s_q.acc}; // RULE9
                    end
                end
            end
            // halt ends only on wake; the phase is already parked at fetch
            mitd_pkg::MITD_SLEEP: begin
                if (wake) begin
                    s_d.fsm = mitd_pkg::MITD_RUN;
                    s_d.sleeping = 1'b0;
                end
            end
        endcase
        // a timeout in the same cycle as a clear still lands
        if (wdt_timeout) begin
            s_d.timeout = 1'b1;
        end
    end

    // one register for the whole state; starting at the fetch phase takes address 0 first
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
            s_q.fsm <= mitd_pkg::MITD_RUN;
            s_q.phase <= mitd_pkg::PH_FETCH;
            s_q.op <= mitd_pkg::OP_NOP;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs are plain copies of state bits, so nothing downstream sees decode glitches
    assign pc = s_q.pc;
    assign fetch = s_q.fetch;
    assign mem_addr = s_q.mem_addr;
    assign mem_wdata = s_q.mem_wdata;
    assign mem_we = s_q.mem_we;
    assign tbl_addr = s_q.tbl_addr;
    assign table_high_byte = s_q.tbl_high;
    assign acc = s_q.acc;
    assign carry = s_q.carry;
    assign timeout_flag = s_q.timeout;
    assign powerdown_flag = s_q.powerdown;
    assign wdt_clear = s_q.wdt_clear;
    assign halted = s_q.sleeping;
    assign int_enable = s_q.int_en;

    // checks sample on the core clock and stay quiet while reset is held
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_jump_two_cycles: assert property (fetch && s_q.op == mitd_pkg::OP_JUMP_ABSOLUTE // RULE5
        |-> ##1 !fetch [*7] ##1 fetch) else $error("jump not two cycles");
    chk_nop_one_cycle: assert property (fetch && s_q.op == mitd_pkg::OP_NOP // RULE10
        |-> ##1 !fetch [*3] ##1 fetch) else $error("no-op not one cycle");
    chk_call_return_len: assert property (fetch && (s_q.op == mitd_pkg::OP_CALL // RULE8
        || s_q.op == mitd_pkg::OP_RETURN) |-> ##8 fetch) else $error("call or return length wrong");
    chk_pcl_extra_cycle: assert property (mem_we && mem_addr == mitd_pkg::PCL_ADDR // RULE15
        && s_q.op == mitd_pkg::OP_MOVE_ACC_TO_MEM |-> !fetch [*5] ##1 fetch)
        else $error("low counter load missed its extra cycle");
    // the skip mark shows one edge after execute, so the old counter lies six edges back
    chk_skip_extra_cycle: assert property ($rose(s_q.skip_taken) // RULE16
        && s_q.op == mitd_pkg::OP_SKIP_IF_ZERO |-> !fetch [*5]
        ##1 (fetch && pc == $past(pc, 6) + PC_W'(2))) else $error("taken skip timing wrong");
    chk_move_keeps_carry: assert property (fetch && s_q.op == mitd_pkg::OP_MOVE_MEM_TO_ACC // RULE3
        |-> ##1 $stable(carry) [*4]) else $error("move altered carry");
    chk_wdt_clears_pdf: assert property (wdt_clear && !halted && s_q.op != mitd_pkg::OP_HALT // RULE11
        |-> !powerdown_flag) else $error("watchdog clear left powerdown set");
    chk_single_preclear: assert property (fetch && s_q.op == mitd_pkg::OP_WATCHDOG_PRECLEAR_FIRST // RULE12
        && !s_q.pend_second |-> !wdt_clear [*5]) else $error("lone preclear cleared watchdog");
    chk_halt_enters_sleep: assert property (fetch && s_q.op == mitd_pkg::OP_HALT // RULE14
        |-> ##4 halted && powerdown_flag) else $error("halt did not power down");
    // read data was taken one edge before the write strobe shows
    chk_rotate_right_data: assert property (mem_we && s_q.op == mitd_pkg::OP_ROTATE_RIGHT // RULE1
        |-> mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[DW-1:1])})
        else $error("right rotate data wrong");
endmodule

// ---- test/tb_mitd_core.sv ----
`timescale 1ns/1ps
module tb_mitd_core;
    logic clk = 1'b0;
    logic reset = 1'b1;
    mitd_pkg::mitd_op_t instr_op = mitd_pkg::OP_NOP;
    logic [2:0] instr_bit = 3'h0;
    logic [12:0] instr_operand = 13'h0000;
    logic [7:0] mem_rdata = 8'h00;
    logic [15:0] tbl_data = 16'h0000;
    logic wdt_timeout = 1'b0;
    logic wake = 1'b0;
    logic [12:0] pc, tbl_addr, op_pc;
    logic fetch, mem_we, carry, timeout_flag, powerdown_flag, wdt_clear, halted, int_enable;
    logic [7:0] mem_addr, mem_wdata, table_high_byte, acc;
    logic [7:0] dmem [256];
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    int wr_cnt = 0;
    int clr_cnt = 0;

    mitd_core dut (.clk(clk), .reset(reset), .instr_op(instr_op), .instr_bit(instr_bit),
        .instr_operand(instr_operand), .mem_rdata(mem_rdata), .tbl_data(tbl_data),
        .wdt_timeout(wdt_timeout), .wake(wake), .pc(pc), .fetch(fetch), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .tbl_addr(tbl_addr), .table_high_byte(table_high_byte),
        .acc(acc), .carry(carry), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
        .wdt_clear(wdt_clear), .halted(halted), .int_enable(int_enable));

    always #5 clk = ~clk;

    // program word as a function of its address, so page mix-ups show in the low byte
    function automatic logic [15:0] tword(logic [12:0] a);
        return {a[7:0] ^ 8'hc3, 3'h5, a[12:8]};
    endfunction

    // memories answer on the falling edge, well before the design samples them
    always @(negedge clk) begin
        mem_rdata <= dmem[mem_addr];
        tbl_data <= tword(tbl_addr);
    end

    // write and watchdog-clear counters, plus the hang ceiling
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (mem_we) begin
            dmem[mem_addr] <= mem_wdata;
            wr_cnt <= wr_cnt + 1;
        end
        if (wdt_clear)
            clr_cnt <= clr_cnt + 1;
        if (cycles > 5000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_len(int exp, int got);
        compares++;
        if (got != exp) begin
            fail_count++;
            $display("MISMATCH clocks expected %0d seen %0d", exp, got);
        end
    endtask

    // held until the next take; returns clocks since the previous fetch (bounded wait)
    task automatic issue(mitd_pkg::mitd_op_t op, logic [2:0] b, logic [12:0] o, output int n);
        instr_op = op;
        instr_bit = b;
        instr_operand = o;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (fetch !== 1'b1 && n < 64);
        @(negedge clk);
    endtask

    // one instruction, then a no-op whose fetch closes the length measurement
    task automatic run(mitd_pkg::mitd_op_t op, logic [2:0] b, logic [12:0] o, int clks);
        int n;
        issue(op, b, o, n);
        op_pc = pc;
        issue(mitd_pkg::OP_NOP, 3'h0, 13'h0000, n);
        chk_len(clks, n);
    endtask

    // all eight rotates share one loop; the enum keeps them in a fixed order
    task automatic t_rotate();
        logic [7:0] v, r, a;
        logic c;
        a = 8'h00;
        c = 1'b0;
        for (int k = 0; k < 8; k++) begin
            v = 8'h81 ^ {k[2:0], 5'h00};
            if (k < 4)
                r = {k[1] ? c : v[0], v[7:1]};
            else
                r = {v[6:0], k[1] ? c : v[7]};
            if (k[1])
                c = (k < 4) ? v[0] : v[7];
            if (k[0])
                a = r;
            dmem[8'h10] = v;
            run(mitd_pkg::mitd_op_t'(k + 1), 3'h0, 13'h0010, 4);
            chk("rot mem", k[0] ? v : r, dmem[8'h10]);
            chk("rot acc", a, acc);
            chk("rot carry", c, carry);
        end
    endtask

    task automatic t_move();
        dmem[8'h20] = 8'h3c;
        run(mitd_pkg::OP_MOVE_MEM_TO_ACC, 3'h0, 13'h0020, 4);
        chk("mov acc", 8'h3c, acc);
        run(mitd_pkg::OP_MOVE_IMM_TO_ACC, 3'h0, 13'h1f77, 4);
        chk("imm acc", 8'h77, acc);
        run(mitd_pkg::OP_MOVE_ACC_TO_MEM, 3'h0, 13'h0021, 4);
        chk("mov mem", 8'h77, dmem[8'h21]);
        run(mitd_pkg::OP_MOVE_ACC_TO_MEM, 3'h0, {5'h00, mitd_pkg::PCL_ADDR}, 8);
        chk("pc low", {op_pc[12:8], 8'h77}, pc);
    endtask

    task automatic t_bits();
        logic [7:0] m;
        for (int i = 0; i < 8; i++) begin
            m = 8'h01 << i;
            dmem[8'h30] = 8'h00;
            run(mitd_pkg::OP_BIT_SET, 3'(i), 13'h0030, 4);
            chk("bit set", m, dmem[8'h30]);
            m = ~m;
            dmem[8'h30] = 8'hff;
            run(mitd_pkg::OP_BIT_CLEAR, 3'(i), 13'h0030, 4);
            chk("bit clear", m, dmem[8'h30]);
        end
    endtask

    // the three returns follow the call in the enum, so one loop walks them
    task automatic t_branch();
        logic [12:0] s;
        run(mitd_pkg::OP_JUMP_ABSOLUTE, 3'h0, 13'h0123, 8);
        chk("jump pc", 13'h0123, pc);
        chk("irq en", 1'b0, int_enable);
        for (int k = 0; k < 3; k++) begin
            run(mitd_pkg::OP_CALL, 3'h0, 13'h0400 + 13'(k), 8);
            chk("call pc", 13'h0400 + 13'(k), pc);
            s = op_pc + 13'h0001;
            run(mitd_pkg::mitd_op_t'(24 + k), 3'h0, 13'h00a5, 8);
            chk("ret pc", s, pc);
        end
        chk("ret acc", 8'ha5, acc);
        chk("irq en", 1'b1, int_enable);
        chk("carry kept", 1'b0, carry);
    endtask

    task automatic t_skip();
        dmem[8'h40] = 8'h00;
        run(mitd_pkg::OP_SKIP_IF_ZERO, 3'h0, 13'h0040, 8);
        chk("skip pc", op_pc + 13'h0002, pc);
        dmem[8'h40] = 8'h10;
        run(mitd_pkg::OP_SKIP_IF_ZERO, 3'h0, 13'h0040, 4);
        chk("noskip pc", op_pc + 13'h0001, pc);
        run(mitd_pkg::OP_SKIP_BIT_ZERO, 3'h4, 13'h0040, 4);
        run(mitd_pkg::OP_SKIP_BIT_ZERO, 3'h3, 13'h0040, 8);
        run(mitd_pkg::OP_SKIP_BIT_NONZERO, 3'h4, 13'h0040, 8);
        run(mitd_pkg::OP_SKIP_ZERO_MOVE_ACC, 3'h0, 13'h0040, 4);
        chk("sza acc", 8'h10, acc);
        dmem[8'h41] = 8'hff;
        run(mitd_pkg::OP_INCREMENT_SKIP_ZERO, 3'h0, 13'h0041, 8);
        chk("inc mem", 8'h00, dmem[8'h41]);
        run(mitd_pkg::OP_INCREMENT_SKIP_ZERO_ACC, 3'h0, 13'h0041, 4);
        chk("inc acc", 8'h01, acc);
        dmem[8'h41] = 8'h01;
        run(mitd_pkg::OP_DECREMENT_SKIP_ZERO_ACC, 3'h0, 13'h0041, 8);
        chk("dec acc", 8'h00, acc);
        run(mitd_pkg::OP_DECREMENT_SKIP_ZERO, 3'h0, 13'h0041, 8);
        chk("dec mem", 8'h00, dmem[8'h41]);
    endtask

    task automatic t_table();
        logic [15:0] t;
        run(mitd_pkg::OP_MOVE_IMM_TO_ACC, 3'h0, 13'h0034, 4);
        run(mitd_pkg::OP_TABLE_READ_CURRENT_PAGE, 3'h0, 13'h0050, 8);
        t = tword({op_pc[12:8], 8'h34});
        chk("tbl low", t[7:0], dmem[8'h50]);
        chk("tbl high", t[15:8], table_high_byte);
        run(mitd_pkg::OP_TABLE_READ_LAST_PAGE, 3'h0, 13'h0050, 8);
        t = tword({5'h1f, 8'h34});
        chk("tbl low", t[7:0], dmem[8'h50]);
        run(mitd_pkg::OP_TABLE_READ_LAST_PAGE, 3'h0, {5'h00, mitd_pkg::PCL_ADDR}, 12);
        chk("tbl pc", {op_pc[12:8], t[7:0]}, pc);
    endtask

    task automatic t_misc();
        int w;
        w = wr_cnt;
        run(mitd_pkg::OP_NOP, 3'h0, 13'h0060, 4);
        chk("nop writes", w[15:0], wr_cnt[15:0]);
        run(mitd_pkg::OP_BYTE_SET, 3'h0, 13'h0060, 4);
        chk("byte set", 8'hff, dmem[8'h60]);
        run(mitd_pkg::OP_BYTE_CLEAR, 3'h0, 13'h0060, 4);
        chk("byte clr", 8'h00, dmem[8'h60]);
        dmem[8'h60] = 8'h3c;
        run(mitd_pkg::OP_NIBBLE_EXCHANGE, 3'h0, 13'h0060, 4);
        chk("swap mem", 8'hc3, dmem[8'h60]);
        run(mitd_pkg::OP_NIBBLE_EXCHANGE_TO_ACC, 3'h0, 13'h0060, 4);
        chk("swap acc", 8'h3c, acc);
        chk("swap kept", 8'hc3, dmem[8'h60]);
    endtask

    // a lone pre-clear half must leave the flags alone; halt waits for wake
    task automatic t_wdt();
        int n, c;
        c = clr_cnt;
        wdt_timeout = 1'b1;
        @(negedge clk);
        wdt_timeout = 1'b0;
        issue(mitd_pkg::OP_HALT, 3'h0, 13'h0000, n);
        instr_op = mitd_pkg::OP_NOP;
        repeat (10) @(negedge clk);
        chk("halted", 1'b1, halted);
        chk("pd halt", 1'b1, powerdown_flag);
        chk("to halt", 1'b0, timeout_flag);
        wake = 1'b1;
        @(negedge clk);
        wake = 1'b0;
        issue(mitd_pkg::OP_NOP, 3'h0, 13'h0000, n);
        chk("awake", 1'b0, halted);
        wdt_timeout = 1'b1;
        @(negedge clk);
        wdt_timeout = 1'b0;
        run(mitd_pkg::OP_WATCHDOG_PRECLEAR_FIRST, 3'h0, 13'h0000, 4);
        chk("to half", 1'b1, timeout_flag);
        chk("clr half", c + 1, clr_cnt);
        run(mitd_pkg::OP_WATCHDOG_PRECLEAR_SECOND, 3'h0, 13'h0000, 4);
        chk("pd pair", 1'b0, powerdown_flag);
        chk("clr pair", c + 2, clr_cnt);
        wdt_timeout = 1'b1;
        @(negedge clk);
        wdt_timeout = 1'b0;
        run(mitd_pkg::OP_WATCHDOG_CLEAR, 3'h0, 13'h0000, 4);
        chk("to clr", 1'b0, timeout_flag);
        chk("clr one", c + 3, clr_cnt);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        t_rotate();
        t_move();
        t_bits();
        t_branch();
        t_skip();
        t_table();
        t_misc();
        t_wdt();
        close_out();
    end
endmodule
